// File: shared/csfl_params.svh
// Behaviour
// - flag register sits at register address fch, read and written like control registers
// - carry, overflow, zero and sign feed conditional jump evaluation
// - half-carry and decimal-adjust serve decimal correction only, never jump conditions
// - two user flags change only on explicit writes or interrupt return, and never feed jumps
// - watchdog refresh instruction forces zero to one, clears sign and overflow
// - arithmetic sets carry on carry out of or borrow into bit 7
// - rotate or shift loads carry with the last bit moved out
// - dedicated instructions set, clear or invert the carry flag
// - interrupt return reloads every flag bit from the stacked image
// - arithmetic and logical results of zero set the zero flag
// - mask tests set zero when the masked result is 00h
// - rotate or shift results of 00h set the zero flag
// - sign flag copies bit 7 of arithmetic, logical, rotate and shift results
// - overflow flags signed range escape beyond 127 or -128; logical ops clear it
// - decimal-adjust flag is one after subtraction, zero after addition
// - half-carry flags carry out of or borrow from bit 3
// - a 4-bit condition field selects one of sixteen functions of c, z, s, v
`ifndef CSFL_PARAMS_SVH
`define CSFL_PARAMS_SVH

`define CSFL_ADDR_W      8
`define CSFL_FLAG_ADDR   8'hfc
`define CSFL_FLAG_RESET  8'h00

`define CSFL_BIT_C       7
`define CSFL_BIT_Z       6
`define CSFL_BIT_S       5
`define CSFL_BIT_V       4
`define CSFL_BIT_D       3
`define CSFL_BIT_H       2
`define CSFL_BIT_U2      1
`define CSFL_BIT_U1      0

`define CSFL_DA_NIBBLE   4'h9
`define CSFL_DA_BYTE     8'h99
`define CSFL_DA_LO_CORR  8'h06
`define CSFL_DA_HI_CORR  8'h60

`endif

// File: shared/csfl_pkg.sv
`default_nettype none
package csfl_pkg;

    typedef enum logic [4:0] {
        op_none   = 5'h00,
        op_add    = 5'h01,
        op_adc    = 5'h02,
        op_sub    = 5'h03,
        op_sbc    = 5'h04,
        op_cp     = 5'h05,
        op_inc    = 5'h06,
        op_dec    = 5'h07,
        op_and    = 5'h08,
        op_or     = 5'h09,
        op_xor    = 5'h0a,
        op_com    = 5'h0b,
        op_mask_test_instr          = 5'h0c,
        op_inverted_mask_test_instr = 5'h0d,
        op_rl     = 5'h0e,
        op_rlc    = 5'h0f,
        op_rr     = 5'h10,
        op_rrc    = 5'h11,
        op_sra    = 5'h12,
        op_swap   = 5'h13,
        op_decimal_correct_instr    = 5'h14,
        op_carry_set_instr          = 5'h15,
        op_carry_clear_instr        = 5'h16,
        op_carry_invert_instr       = 5'h17,
        op_watchdog_refresh_instr   = 5'h18,
        op_interrupt_return_instr   = 5'h19
    } csfl_op_t;

    typedef enum logic [3:0] {
        cond_never = 4'h0,
        cond_lt    = 4'h1,
        cond_le    = 4'h2,
        cond_ule   = 4'h3,
        cond_ov    = 4'h4,
        cond_mi    = 4'h5,
        cond_zero  = 4'h6,
        cond_cy    = 4'h7,
        cond_always= 4'h8,
        cond_ge    = 4'h9,
        cond_gt    = 4'ha,
        cond_ugt   = 4'hb,
        cond_nov   = 4'hc,
        cond_pl    = 4'hd,
        cond_nz    = 4'he,
        cond_nc    = 4'hf
    } csfl_cond_t;

endpackage : csfl_pkg
`default_nettype wire

// File: verilog/csfl_cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
`include "csfl_params.svh"
module csfl_cond_eval
    import csfl_pkg::*;
(
    input  wire logic [3:0] jump_condition_field_i,
    input  wire logic       carry_i,
    input  wire logic       zero_i,
    input  wire logic       sign_i,
    input  wire logic       ovf_i,
    output logic            taken_o
);

    logic lt;

    // only c, z, s, v enter here; h, d and user bits have no path in
    assign lt = sign_i ^ ovf_i;

    always_comb begin
        case (csfl_cond_t'(jump_condition_field_i))
            cond_never:  taken_o = 1'b0;
            cond_lt:     taken_o = lt;
            cond_le:     taken_o = zero_i | lt;
            cond_ule:    taken_o = carry_i | zero_i;
            cond_ov:     taken_o = ovf_i;
            cond_mi:     taken_o = sign_i;
            cond_zero:   taken_o = zero_i;
            cond_cy:     taken_o = carry_i;
            cond_always: taken_o = 1'b1;
            cond_ge:     taken_o = ~lt;
            cond_gt:     taken_o = ~(zero_i | lt);
            cond_ugt:    taken_o = ~carry_i & ~zero_i;
            cond_nov:    taken_o = ~ovf_i;
            cond_pl:     taken_o = ~sign_i;
            cond_nz:     taken_o = ~zero_i;
            default:     taken_o = ~carry_i;
        endcase
    end

endmodule : csfl_cond_eval
`default_nettype wire

// File: verilog/csfl_top.sv
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "csfl_params.svh"
module csfl_top
    import csfl_pkg::*;
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [`CSFL_ADDR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    input  wire logic                     op_valid_i,
    input  wire logic [4:0]               op_i,
    input  wire logic [7:0]               dst_i,
    input  wire logic [7:0]               src_i,
    input  wire logic [7:0]               stack_flags_i,
    input  wire logic [3:0]               jump_condition_field_i,
    output logic      [7:0]               flags_o,
    output logic      [7:0]               result_o,
    output logic                          result_we_o,
    output logic                          cond_true_o
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // register bus slave

    logic       ack_r;
    logic [7:0] flag_r;
    logic [7:0] flag_nxt;
    logic       bus_req;
    logic       hit;
    logic       bus_wr;
    csfl_op_t   op;

    assign op      = csfl_op_t'(op_i);
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign hit     = (wb_adr_i[`CSFL_ADDR_W-1:2] == (`CSFL_ADDR_W-2)'(`CSFL_FLAG_ADDR >> 2));
    // only byte lane 0 carries the flags
    assign bus_wr  = bus_req & wb_we_i & hit & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            // one-cycle ack, dropped the cycle after it is given
            ack_r <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~wb_we_i) begin
            if (hit) begin
                wb_dat_o <= {24'h00_0000, flag_r};
            end else begin
                // unmapped words read as zero, writes to them vanish
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_r;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // flag computation

    logic       c_in;
    logic [8:0] wide;
    logic [4:0] half;
    logic [7:0] res;
    logic       res_we;
    logic       is_sub;
    logic [7:0] operand_b;
    logic       cin;
    logic       corr_lo;
    logic       corr_hi;
    logic [7:0] corr;

    assign c_in = flag_r[`CSFL_BIT_C];

    always_comb begin
        flag_nxt  = flag_r;
        res       = dst_i;
        res_we    = 1'b0;
        wide      = 9'h000;
        half      = 5'h00;
        is_sub    = 1'b0;
        operand_b = src_i;
        cin       = 1'b0;
        corr_lo   = 1'b0;
        corr_hi   = 1'b0;
        corr      = 8'h00;
        case (op)
            op_add, op_adc, op_inc, op_sub, op_sbc, op_cp, op_dec: begin
                is_sub = (op == op_sub) || (op == op_sbc) || (op == op_cp) || (op == op_dec);
                if ((op == op_inc) || (op == op_dec)) begin
                    operand_b = 8'h01;
                end
                if ((op == op_adc) || (op == op_sbc)) begin
                    cin = c_in;
                end
                if (is_sub) begin
                    wide = {1'b0, dst_i} - {1'b0, operand_b} - {8'h00, cin};
                    half = {1'b0, dst_i[3:0]} - {1'b0, operand_b[3:0]} - {4'h0, cin};
                end else begin
                    wide = {1'b0, dst_i} + {1'b0, operand_b} + {8'h00, cin};
                    half = {1'b0, dst_i[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, cin};
                end
                res    = wide[7:0];
                res_we = (op != op_cp);
                // increment and decrement leave carry, half-carry and decimal flags alone
                if ((op != op_inc) && (op != op_dec)) begin
                    flag_nxt[`CSFL_BIT_C] = wide[8];
                end
                if ((op != op_inc) && (op != op_dec) && (op != op_cp)) begin
                    flag_nxt[`CSFL_BIT_H] = half[4];
                    flag_nxt[`CSFL_BIT_D] = is_sub;
                end
                flag_nxt[`CSFL_BIT_Z] = (wide[7:0] == 8'h00);
                flag_nxt[`CSFL_BIT_S] = wide[7];
                if (is_sub) begin
                    flag_nxt[`CSFL_BIT_V] = (dst_i[7] != operand_b[7]) && (wide[7] != dst_i[7]);
                end else begin
                    flag_nxt[`CSFL_BIT_V] = (dst_i[7] == operand_b[7]) && (wide[7] != dst_i[7]);
                end
            end
            op_and, op_or, op_xor, op_com: begin
                case (op)
                    op_and:  res = dst_i & src_i;
                    op_or:   res = dst_i | src_i;
                    op_xor:  res = dst_i ^ src_i;
                    default: res = ~dst_i;
                endcase
                res_we = 1'b1;
                flag_nxt[`CSFL_BIT_Z] = (res == 8'h00);
                flag_nxt[`CSFL_BIT_S] = res[7];
                flag_nxt[`CSFL_BIT_V] = 1'b0;
            end
            op_mask_test_instr, op_inverted_mask_test_instr: begin
                // tests never write the destination back
                if (op == op_mask_test_instr) begin
                    res = dst_i & src_i;
                end else begin
                    res = ~dst_i & src_i;
                end
                flag_nxt[`CSFL_BIT_Z] = (res == 8'h00);
                flag_nxt[`CSFL_BIT_S] = res[7];
                flag_nxt[`CSFL_BIT_V] = 1'b0;
            end
            op_rl, op_rlc, op_rr, op_rrc, op_sra, op_swap: begin
                case (op)
                    op_rl:   res = {dst_i[6:0], dst_i[7]};
                    op_rlc:  res = {dst_i[6:0], c_in};
                    op_rr:   res = {dst_i[0], dst_i[7:1]};
                    op_rrc:  res = {c_in, dst_i[7:1]};
                    op_sra:  res = {dst_i[7], dst_i[7:1]};
                    default: res = {dst_i[3:0], dst_i[7:4]};
                endcase
                res_we = 1'b1;
                // a nibble swap moves no single bit out, so carry and overflow keep their value
                if (op != op_swap) begin
                    if ((op == op_rl) || (op == op_rlc)) begin
                        flag_nxt[`CSFL_BIT_C] = dst_i[7];
                    end else begin
                        flag_nxt[`CSFL_BIT_C] = dst_i[0];
                    end
                    // sign change through the move is the signed range escape
                    flag_nxt[`CSFL_BIT_V] = res[7] ^ dst_i[7];
                end
                flag_nxt[`CSFL_BIT_Z] = (res == 8'h00);
                flag_nxt[`CSFL_BIT_S] = res[7];
            end
            op_decimal_correct_instr: begin
                corr_lo = flag_r[`CSFL_BIT_H] | (dst_i[3:0] > `CSFL_DA_NIBBLE);
                corr_hi = c_in | (dst_i > `CSFL_DA_BYTE);
                corr    = (corr_lo ? `CSFL_DA_LO_CORR : 8'h00) | (corr_hi ? `CSFL_DA_HI_CORR : 8'h00);
                // direction of correction comes from the decimal-adjust flag
                if (flag_r[`CSFL_BIT_D]) begin
                    res = dst_i - corr;
                end else begin
                    res = dst_i + corr;
                    flag_nxt[`CSFL_BIT_C] = corr_hi;
                end
                res_we = 1'b1;
                flag_nxt[`CSFL_BIT_Z] = (res == 8'h00);
                flag_nxt[`CSFL_BIT_S] = res[7];
            end
            op_carry_set_instr: begin
                flag_nxt[`CSFL_BIT_C] = 1'b1;
            end
            op_carry_clear_instr: begin
                flag_nxt[`CSFL_BIT_C] = 1'b0;
            end
            op_carry_invert_instr: begin
                flag_nxt[`CSFL_BIT_C] = ~c_in;
            end
            op_watchdog_refresh_instr: begin
                flag_nxt[`CSFL_BIT_Z] = 1'b1;
                flag_nxt[`CSFL_BIT_S] = 1'b0;
                flag_nxt[`CSFL_BIT_V] = 1'b0;
            end
            op_interrupt_return_instr: begin
                flag_nxt = stack_flags_i;
            end
            default: begin
                flag_nxt = flag_r;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // flag register; bit positions fixed by the field macros

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_r <= `CSFL_FLAG_RESET;
        end else if (bus_wr) begin
            flag_r <= wb_dat_i[7:0];
        end else if (op_valid_i) begin
            // user bits untouched by every op except the full restore
            flag_r <= flag_nxt;
        end
    end

    assign flags_o = flag_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o    <= 8'h00;
            result_we_o <= 1'b0;
        end else begin
            result_we_o <= op_valid_i & res_we;
            if (op_valid_i & res_we) begin
                result_o <= res;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // jump condition; one cycle behind the flags it sees

    logic taken;

    csfl_cond_eval u_cond (
        .jump_condition_field_i (jump_condition_field_i),
        .carry_i                (flag_r[`CSFL_BIT_C]),
        .zero_i                 (flag_r[`CSFL_BIT_Z]),
        .sign_i                 (flag_r[`CSFL_BIT_S]),
        .ovf_i                  (flag_r[`CSFL_BIT_V]),
        .taken_o                (taken)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cond_true_o <= 1'b0;
        end else begin
            cond_true_o <= taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [8:0] chk_add;
    logic [4:0] chk_half;
    logic       upd;

    assign chk_add  = {1'b0, dst_i} + {1'b0, src_i};
    assign chk_half = {1'b0, dst_i[3:0]} + {1'b0, src_i[3:0]};
    assign upd      = op_valid_i & ~bus_wr;

    a_wdt_flag_force: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_watchdog_refresh_instr |=> flag_r[`CSFL_BIT_Z] && !flag_r[`CSFL_BIT_S]
            && !flag_r[`CSFL_BIT_V]
    ) else $error("watchdog op left z, s or v wrong");

    a_add_carry_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_add |=> flag_r[`CSFL_BIT_C] == $past(chk_add[8])
    ) else $error("add carry mismatch");

    a_add_half_carry: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_add |=> flag_r[`CSFL_BIT_H] == $past(chk_half[4])
    ) else $error("add half-carry mismatch");

    a_rotate_carry_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && (op == op_rr || op == op_rrc || op == op_sra) |=> flag_r[`CSFL_BIT_C] == $past(dst_i[0])
    ) else $error("right move carry is not the bit shifted out");

    a_carry_invert: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_carry_invert_instr |=> flag_r[`CSFL_BIT_C] != $past(flag_r[`CSFL_BIT_C])
    ) else $error("carry not inverted");

    a_return_restore: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_interrupt_return_instr |=> flag_r == $past(stack_flags_i)
    ) else $error("flags not restored from stack image");

    a_logic_zero_sign: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && (op == op_and || op == op_or || op == op_xor) ##1 result_we_o
            |-> flag_r[`CSFL_BIT_Z] == (result_o == 8'h00) && flag_r[`CSFL_BIT_S] == result_o[7]
            && !flag_r[`CSFL_BIT_V]
    ) else $error("logic op zero, sign or overflow wrong");

    a_mask_test_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && op == op_mask_test_instr |=> flag_r[`CSFL_BIT_Z] == ($past(dst_i & src_i) == 8'h00)
    ) else $error("mask test zero wrong");

    a_shift_sign_copy: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && (op == op_rl || op == op_sra) |=> result_we_o && flag_r[`CSFL_BIT_S] == result_o[7]
            && flag_r[`CSFL_BIT_Z] == (result_o == 8'h00)
    ) else $error("shift sign or zero wrong");

    a_sub_decimal_flag: assert property (
        @(posedge clk_i) disable iff (rst_i)
        upd && (op == op_sub || op == op_sbc) |=> flag_r[`CSFL_BIT_D]
    ) else $error("decimal flag not set after subtract");

    a_user_bits_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !bus_wr && !(op_valid_i && op == op_interrupt_return_instr)
            |=> $stable(flag_r[`CSFL_BIT_U2:`CSFL_BIT_U1])
    ) else $error("user flags changed without a write");

    a_bus_write_wins: assert property (
        @(posedge clk_i) disable iff (rst_i)
        bus_wr |=> flag_r == $past(wb_dat_i[7:0]) ##1 !wb_ack_o
    ) else $error("bus write lost against a flag update");

    a_cond_follows_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        jump_condition_field_i == 4'h6 |=> cond_true_o == $past(flag_r[`CSFL_BIT_Z])
    ) else $error("zero condition does not follow zero flag");

endmodule : csfl_top
`default_nettype wire

// File: test/csfl_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "csfl_params.svh"
module csfl_top_tb
    import csfl_pkg::*;
;
    logic        clk_i                  = 1'b0;
    logic        rst_i                  = 1'b1;
    logic        wb_cyc_i               = 1'b0;
    logic        wb_stb_i               = 1'b0;
    logic        wb_we_i                = 1'b0;
    logic [7:0]  wb_adr_i               = 8'h00;
    logic [3:0]  wb_sel_i               = 4'h0;
    logic [31:0] wb_dat_i               = 32'h0;
    logic        op_valid_i             = 1'b0;
    logic [4:0]  op_i                   = 5'h00;
    logic [7:0]  dst_i                  = 8'h00;
    logic [7:0]  src_i                  = 8'h00;
    logic [7:0]  stack_flags_i          = 8'h00;
    logic [3:0]  jump_condition_field_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  flags_o;
    logic [7:0]  result_o;
    logic        result_we_o;
    logic        cond_true_o;
    int          err_total              = 0;
    int          comparisons            = 0;
    integer      seed                   = 71;
    logic [7:0]  exp_f                  = 8'h00;
    csfl_op_t    tbl [25] = '{op_add, op_adc, op_sub, op_sbc, op_and, op_or, op_xor, op_mask_test_instr,
        op_inverted_mask_test_instr, op_rl, op_rlc, op_rr, op_rrc, op_sra, op_carry_set_instr,
        op_carry_clear_instr, op_carry_invert_instr, op_watchdog_refresh_instr, op_interrupt_return_instr,
        op_cp, op_inc, op_dec, op_com, op_swap, op_decimal_correct_instr};

    always #5 clk_i = ~clk_i;

    csfl_top u_csfl_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i), .op_i(op_i), .dst_i(dst_i), .src_i(src_i),
        .stack_flags_i(stack_flags_i), .jump_condition_field_i(jump_condition_field_i),
        .flags_o(flags_o), .result_o(result_o), .result_we_o(result_we_o), .cond_true_o(cond_true_o)
    );

////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // op rides along only for the bus-versus-op collision case
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat, input csfl_op_t op, output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i   <= 1'b1;
        wb_stb_i   <= 1'b1;
        wb_we_i    <= we;
        wb_adr_i   <= adr;
        wb_sel_i   <= sel;
        wb_dat_i   <= dat;
        op_i       <= op;
        dst_i      <= 8'hff;
        src_i      <= 8'h01;
        op_valid_i <= (op != op_none);
        n = 0;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            test_done();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb_xfer

////////////////////////////////////////////////////////////////////////////////
    // returns {result written, result, flags}
    function automatic logic [16:0] model(csfl_op_t op, logic [7:0] d, logic [7:0] s, logic [7:0] f);
        logic [8:0] w;
        logic       ci;
        logic       zs;
        logic [7:0] f0;
        f0 = f;
        ci = (op == op_adc || op == op_sbc) ? f[`CSFL_BIT_C] : 1'b0;
        w  = 9'h000;
        zs = op inside {[op_add:op_com], [op_mask_test_instr:op_decimal_correct_instr]};
        if (op inside {op_inc, op_dec}) begin
            s = 8'h01;
        end
        case (op)
            op_add, op_adc, op_inc: begin
                w = d + s + ci;
                f[`CSFL_BIT_H] = ({1'b0, d[3:0]} + s[3:0] + ci) > 5'h0f;
                f[`CSFL_BIT_V] = (d[7] == s[7]) && (w[7] != d[7]);
                f[`CSFL_BIT_D] = 1'b0;
            end
            op_sub, op_sbc, op_cp, op_dec: begin
                w = d - s - ci;
                f[`CSFL_BIT_H] = {1'b0, d[3:0]} < (s[3:0] + ci);
                f[`CSFL_BIT_V] = (d[7] != s[7]) && (w[7] != d[7]);
                f[`CSFL_BIT_D] = 1'b1;
            end
            op_and:                      w = {1'b0, d & s};
            op_or:                       w = {1'b0, d | s};
            op_xor:                      w = {1'b0, d ^ s};
            op_com:                      w = {1'b0, ~d};
            op_mask_test_instr:          w = {1'b0, d & s};
            op_inverted_mask_test_instr: w = {1'b0, ~d & s};
            op_rl:                       w = {d[7], d[6:0], d[7]};
            op_rlc:                      w = {d[7], d[6:0], f[`CSFL_BIT_C]};
            op_rr:                       w = {d[0], d[0], d[7:1]};
            op_rrc:                      w = {d[0], f[`CSFL_BIT_C], d[7:1]};
            op_sra:                      w = {d[0], d[7], d[7:1]};
            op_swap:                     w = {1'b0, d[3:0], d[7:4]};
            op_decimal_correct_instr: begin
                w = {1'b0, (f[`CSFL_BIT_C] || d > `CSFL_DA_BYTE) ? `CSFL_DA_HI_CORR : 8'h00};
                w = w | {1'b0, (f[`CSFL_BIT_H] || d[3:0] > `CSFL_DA_NIBBLE) ? `CSFL_DA_LO_CORR : 8'h00};
                f[`CSFL_BIT_C] = f[`CSFL_BIT_D] ? f[`CSFL_BIT_C] : w[6];
                w = {1'b0, f[`CSFL_BIT_D] ? d - w[7:0] : d + w[7:0]};
            end
            op_carry_set_instr:          f[`CSFL_BIT_C] = 1'b1;
            op_carry_clear_instr:        f[`CSFL_BIT_C] = 1'b0;
            op_carry_invert_instr:       f[`CSFL_BIT_C] = ~f[`CSFL_BIT_C];
            op_watchdog_refresh_instr: begin
                f[`CSFL_BIT_Z] = 1'b1;
                f[`CSFL_BIT_S] = 1'b0;
                f[`CSFL_BIT_V] = 1'b0;
            end
            op_interrupt_return_instr:   f = s;
            default: ;
        endcase
        if (op inside {[op_add:op_cp], [op_rl:op_sra]}) begin
            f[`CSFL_BIT_C] = w[8];
        end
        if (op inside {[op_rl:op_sra]}) begin
            f[`CSFL_BIT_V] = w[7] ^ d[7];
        end
        if (op inside {[op_and:op_com], op_mask_test_instr, op_inverted_mask_test_instr}) begin
            f[`CSFL_BIT_V] = 1'b0;
        end
        // compare, increment and decrement keep decimal and half-carry
        if (op inside {[op_cp:op_dec]}) begin
            f[`CSFL_BIT_D:`CSFL_BIT_H] = f0[`CSFL_BIT_D:`CSFL_BIT_H];
        end
        if (zs) begin
            f[`CSFL_BIT_Z] = (w[7:0] == 8'h00);
            f[`CSFL_BIT_S] = w[7];
        end
        return {zs && !(op inside {op_cp, op_mask_test_instr, op_inverted_mask_test_instr}), w[7:0], f};
    endfunction : model

    function automatic logic cond_exp(logic [7:0] f, logic [3:0] cc);
        logic       c, z, s, v;
        logic [7:0] b;
        c = f[`CSFL_BIT_C];
        z = f[`CSFL_BIT_Z];
        s = f[`CSFL_BIT_S];
        v = f[`CSFL_BIT_V];
        b = {c, z, s, v, c | z, z | (s ^ v), s ^ v, 1'b0};
        return b[cc[2:0]] ^ cc[3];
    endfunction : cond_exp

    // valid dropped after one edge so carry-chained ops never run twice
    task automatic do_op(input csfl_op_t op, input logic [7:0] d, input logic [7:0] s);
        logic [16:0] e;
        e = model(op, d, s, exp_f);
        @(posedge clk_i);
        op_valid_i    <= 1'b1;
        op_i          <= op;
        dst_i         <= d;
        src_i         <= s;
        stack_flags_i <= s;
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        #1;
        exp_f = e[7:0];
        chk(32'(flags_o), 32'(exp_f));
        chk(32'({result_we_o, e[16] ? result_o : 8'h00}), 32'({e[16], e[15:8] & {8{e[16]}}}));
    endtask : do_op

    task automatic rnd_ops(input int n);
        for (int i = 0; i < n; i++) begin
            do_op(tbl[$unsigned($random(seed)) % 25], 8'($random(seed)), 8'($random(seed)));
        end
    endtask : rnd_ops

////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] rd;
        logic [7:0]  v;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'(flags_o), 32'h0);
        v = 8'($random(seed));
        wb_xfer(1'b1, 8'hfc, 4'hf, {24'h0, v}, op_none, rd);
        wb_xfer(1'b1, 8'hfc, 4'he, {24'h0, ~v}, op_none, rd);
        wb_xfer(1'b1, 8'h10, 4'hf, 32'h0, op_none, rd);
        wb_xfer(1'b0, 8'h10, 4'hf, 32'h0, op_none, rd);
        chk(rd, 32'h0);
        wb_xfer(1'b0, 8'hfc, 4'hf, 32'h0, op_none, rd);
        chk(rd, {24'h0, v});
        exp_f = v;
        // boundary sums and differences first
        do_op(op_add, 8'hff, 8'h01);
        do_op(op_add, 8'h7f, 8'h01);
        do_op(op_sub, 8'h00, 8'h01);
        do_op(op_sub, 8'h80, 8'h01);
        do_op(op_carry_invert_instr, 8'h00, 8'h00);
        rnd_ops(400);
        for (int k = 0; k < 24; k++) begin
            v = 8'($random(seed));
            wb_xfer(1'b1, 8'hfc, 4'h1, {24'h0, v}, op_none, rd);
            for (int cc = 0; cc < 16; cc++) begin
                @(posedge clk_i);
                jump_condition_field_i <= 4'(cc);
                @(posedge clk_i);
                #1;
                chk(32'(cond_true_o), 32'(cond_exp(v, 4'(cc))));
            end
        end
        v = 8'($random(seed));
        wb_xfer(1'b1, 8'hfc, 4'h1, {24'h0, v}, op_add, rd);
        #1;
        chk(32'(flags_o), 32'(v));
        exp_f = v;
        rnd_ops(20);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk(32'({wb_ack_o, cond_true_o, result_we_o, result_o, flags_o}), 32'h0);
        exp_f = 8'h00;
        @(posedge clk_i);
        rnd_ops(40);
        test_done();
    end
endmodule : csfl_top_tb
`default_nettype wire
